// ==== design/cip_top.sv ====
// Counter interrupt prioritizer with APB registers
// How it works
// - Raising an interrupt drives the configured shared byte bit to one.
// - Single source signalled within 20 us basic, 250 us extended.
// - With counter 6/7 comparator on, single limit is 70 us basic.
// - Several pending sources served in priority, highest within 20/250 us.
// - Lowest of n simultaneous signalled within n times 50/250 us.
// - Comparator on 6/7 may add up to 50 us more.
// - A running control word lengthens reaction by its processing time.
// - Highest first; its command list completes before next is raised.
// - Outputs 1-5, gates 1-5, resets 6-7; outputs 6-7 only with comparator.
// - Sources: counter outputs 1-7, gates 1-5, resets 6-7, module errors.
// - Source needs its own enable and the global trigger enable.
// - Module errors interrupt only with the error interrupt enable.
// - After start-up every source is disabled.
// - Extended filter runs a command list without signalling the host.
// - While output disable is active, events are stored, not raised.
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module cip_top #(
  parameter int T_LIMIT_CYC = (cip_pkg::T_EXT_NS + cip_pkg::CLK_NS - 1) / cip_pkg::CLK_NS
) (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST_B,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Event inputs from counters and module
  input  wire logic [cip_pkg::NSRC-1:0] SRC_EVENT,
  input  wire logic        CTRL_WORD_BUSY,
  // Host side
  input  wire logic        OUTPUT_DISABLE_COMMAND,
  output logic             INT_LINE,
  output logic      [7:0]  SHARED_INTERRUPT_BYTE,
  output logic             LIST_START,
  output logic      [3:0]  LIST_SRC,
  output logic             IRQ
);

  localparam int N = cip_pkg::NSRC;

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (T_LIMIT_CYC < 1) begin : g_bad_limit
    $error("T_LIMIT_CYC must be at least one");
  end
  // Source index travels in four bits
  if (N > 16) begin : g_bad_nsrc
    $error("NSRC does not fit the four bit source index");
  end
  // Errors keep the lowest priority
  if (cip_pkg::SRC_ERR != N - 1) begin : g_bad_err
    $error("error source must be the last source");
  end
  // Control bits sit above the source enables
  if (cip_pkg::EN_GLOBAL_BIT < N || cip_pkg::EN_ERROR_BIT < N ||
      cip_pkg::EN_CMP67_BIT < N) begin : g_bad_en
    $error("enable control bits overlap the source enables");
  end

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [N-1:0] s1;
  logic [N-1:0] s2;
  logic [N-1:0] s3;
  logic [2:0]   od_sync;
  logic         od_active;
  logic [N-1:0] src_rise;

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= SRC_EVENT;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      od_sync   <= 3'h0;
      od_active <= 1'b0;
    end else begin
      od_sync <= {od_sync[1:0], OUTPUT_DISABLE_COMMAND};
      // Level follows once two stages agree
      if (od_sync[1] == od_sync[2]) begin
        od_active <= od_sync[2];
      end
    end
  end

  // Event counts when the second stage is high and the third stage is still low
  assign src_rise = s2 & ~s3;

  // ****************************************
  // Registers
  // ****************************************
  cip_pkg::cip_apb_req_t req;
  logic [31:0] enable_reg;
  logic [N-1:0] filter_reg;
  logic [N-1:0] list_reg;
  logic [3:0]  config_reg;
  logic [cip_pkg::NSTAT-1:0] status;
  logic [cip_pkg::NSTAT-1:0] mask;
  logic [cip_pkg::NSTAT-1:0] stat_set;
  logic [N-1:0] pending;
  logic        wr_en;
  logic        rd_setup;
  logic        list_done_wr;
  logic        stat_rd;

  assign req     = '{sel: PSEL, enable: PENABLE, write: PWRITE, addr: PADDR, wdata: PWDATA};
  assign wr_en   = req.sel && req.enable && req.write;
  assign rd_setup = req.sel && !req.enable && !req.write;
  // Status clears at the setup edge, where its read data is captured
  assign stat_rd  = rd_setup && (req.addr == cip_pkg::OFF_STATUS);
  assign list_done_wr = wr_en && (req.addr == cip_pkg::OFF_CLDONE);

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      enable_reg <= 32'h0000_0000;
      filter_reg <= '0;
      list_reg   <= '0;
      config_reg <= 4'h0;
      mask       <= '0;
    end else if (wr_en) begin
      case (req.addr)
        cip_pkg::OFF_ENABLE: enable_reg <= req.wdata;
        cip_pkg::OFF_FILTER: filter_reg <= req.wdata[N-1:0];
        cip_pkg::OFF_CONFIG: config_reg <= req.wdata[3:0];
        cip_pkg::OFF_MASK:   mask       <= req.wdata[cip_pkg::NSTAT-1:0];
        cip_pkg::OFF_CLLIST: list_reg   <= req.wdata[N-1:0];
        default: ;
      endcase
    end
  end

  logic        addr_ok;
  // Unmapped offsets answer with an error
  always_comb begin
    case (req.addr)
      cip_pkg::OFF_ENABLE, cip_pkg::OFF_FILTER, cip_pkg::OFF_CONFIG, cip_pkg::OFF_PENDING,
      cip_pkg::OFF_STATUS, cip_pkg::OFF_MASK, cip_pkg::OFF_CLDONE,
      cip_pkg::OFF_CLLIST: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      // Read data taken at setup; access lasts one cycle
      PREADY  <= req.sel && !req.enable;
      PSLVERR <= req.sel && !req.enable && !addr_ok;
      PRDATA  <= 32'h0000_0000;
      if (rd_setup) begin
        case (req.addr)
          cip_pkg::OFF_ENABLE:  PRDATA <= enable_reg;
          cip_pkg::OFF_FILTER:  PRDATA <= 32'(filter_reg);
          cip_pkg::OFF_CONFIG:  PRDATA <= 32'(config_reg);
          cip_pkg::OFF_PENDING: PRDATA <= 32'(pending);
          cip_pkg::OFF_STATUS:  PRDATA <= 32'(status);
          cip_pkg::OFF_MASK:    PRDATA <= 32'(mask);
          cip_pkg::OFF_CLLIST:  PRDATA <= 32'(list_reg);
          default:              PRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************
  // Source qualification
  // ****************************************
  logic         ext_variant;
  logic         cmp67;
  logic [N-1:0] src_ok;
  logic [N-1:0] qualified;

  assign ext_variant = config_reg[cip_pkg::CFG_EXT_BIT];
  assign cmp67       = enable_reg[cip_pkg::EN_CMP67_BIT];

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_src
      if (g == cip_pkg::SRC_ERR) begin : g_err
        assign src_ok[g] = enable_reg[cip_pkg::EN_ERROR_BIT];
      end else if (g == cip_pkg::SRC_OUT6 || g == cip_pkg::SRC_OUT7) begin : g_cmp
        assign src_ok[g] = enable_reg[g] && cmp67;
      end else begin : g_norm
        assign src_ok[g] = enable_reg[g];
      end
    end
  endgenerate

  // Only a rising edge of an enabled source counts
  assign qualified = src_rise & src_ok & {N{enable_reg[cip_pkg::EN_GLOBAL_BIT]}};

  // ****************************************
  // Priority service
  // ****************************************
  cip_pkg::cip_state_t state;
  logic [3:0]   cur;
  logic [N-1:0] grant;
  logic [3:0]   grant_idx;
  logic         grant_any;
  logic         serve_ok;

  // Lowest index wins: outputs, gates, resets, then outputs 6/7 and errors
  always_comb begin
    grant_idx = 4'h0;
    grant_any = 1'b0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pending[i]) begin
        grant_idx = 4'(i);
        grant_any = 1'b1;
      end
    end
  end
  assign grant = grant_any ? (N'(1) << grant_idx) : '0;

  // Service waits for output disable and a running control word
  assign serve_ok = grant_any && !od_active && !CTRL_WORD_BUSY;

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pending <= '0;
    end else begin
      // Set wins over the service clear
      pending <= (pending & ~((state == cip_pkg::ST_IDLE && serve_ok) ? grant : '0))
                 | qualified;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state      <= cip_pkg::ST_IDLE;
      cur        <= 4'h0;
      LIST_START <= 1'b0;
      LIST_SRC   <= 4'h0;
      INT_LINE   <= 1'b0;
      SHARED_INTERRUPT_BYTE <= 8'h00;
    end else begin
      LIST_START <= 1'b0;
      INT_LINE   <= 1'b0;
      SHARED_INTERRUPT_BYTE <= 8'h00;
      case (state)
        cip_pkg::ST_IDLE: begin
          // Highest pending source first
          if (serve_ok) begin
            cur <= grant_idx;
            if (list_reg[grant_idx]) begin
              LIST_START <= 1'b1;
              LIST_SRC   <= grant_idx;
              state      <= cip_pkg::ST_LIST;
            end else begin
              state <= cip_pkg::ST_RAISE;
            end
          end
        end
        cip_pkg::ST_LIST: begin
          // List runs outside; software reports its end
          if (list_done_wr) begin
            state <= (ext_variant && filter_reg[cur]) ? cip_pkg::ST_IDLE
                                                       : cip_pkg::ST_RAISE;
          end
        end
        cip_pkg::ST_RAISE: begin
          // Raise waits while output disable holds
          if (!od_active) begin
            INT_LINE <= 1'b1;
            SHARED_INTERRUPT_BYTE <= 8'h01 << config_reg[2:0];
            state <= cip_pkg::ST_IDLE;
          end
        end
        default: state <= cip_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Reaction time watchdog
  // ****************************************
  localparam int LIM_BASIC = cip_pkg::T_BASIC_NS / cip_pkg::CLK_NS;
  localparam int LIM_BCMP  = cip_pkg::T_BASIC_CMP_NS / cip_pkg::CLK_NS;
  logic [31:0] wait_cnt;
  logic [31:0] limit;

  always_comb begin
    if (ext_variant) begin
      limit = 32'(T_LIMIT_CYC);
    end else if (cmp67) begin
      limit = 32'(LIM_BCMP);
    end else begin
      limit = 32'(LIM_BASIC);
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wait_cnt <= 32'h0000_0000;
    end else if (state != cip_pkg::ST_IDLE || !grant_any || od_active || CTRL_WORD_BUSY) begin
      wait_cnt <= 32'h0000_0000;
    end else if (wait_cnt != 32'hffff_ffff) begin
      // Saturate so a long wait flags late once
      wait_cnt <= wait_cnt + 32'h0000_0001;
    end
  end

  // ****************************************
  // Interrupt status
  // ****************************************
  assign stat_set[cip_pkg::ST_RAISED] = (state == cip_pkg::ST_RAISE) && !od_active;
  assign stat_set[cip_pkg::ST_HELD]   = od_active && |qualified;
  assign stat_set[cip_pkg::ST_LATE]   = (wait_cnt == limit);

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      status <= '0;
      IRQ    <= 1'b0;
    end else begin
      // Set wins over the read clear
      status <= (stat_rd ? '0 : status) | stat_set;
      IRQ    <= |(((stat_rd ? '0 : status) | stat_set) & mask);
    end
  end

endmodule : cip_top

// ==== include/cip_pkg.sv ====
// Package: register map, fields and timing constants of the counter interrupt prioritizer
package cip_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [11:0] OFF_ENABLE  = 12'h000;
  localparam logic [11:0] OFF_FILTER  = 12'h004;
  localparam logic [11:0] OFF_CONFIG  = 12'h008;
  localparam logic [11:0] OFF_PENDING = 12'h00c;
  localparam logic [11:0] OFF_STATUS  = 12'h010;
  localparam logic [11:0] OFF_MASK    = 12'h014;
  localparam logic [11:0] OFF_CLDONE  = 12'h018;
  localparam logic [11:0] OFF_CLLIST  = 12'h01c;

  // ****************************************
  // Source numbering, fixed priority order
  // ****************************************
  localparam int NSRC      = 15;
  localparam int SRC_OUT1  = 0;
  localparam int SRC_OUT2  = 1;
  localparam int SRC_OUT3  = 2;
  localparam int SRC_OUT4  = 3;
  localparam int SRC_OUT5  = 4;
  localparam int SRC_GATE1 = 5;
  localparam int SRC_RST6  = 10;
  localparam int SRC_OUT6  = 12;
  localparam int SRC_OUT7  = 13;
  localparam int SRC_ERR   = 14;

  // ****************************************
  // Enable register fields
  // ****************************************
  localparam int EN_GLOBAL_BIT = 16;
  localparam int EN_ERROR_BIT  = 17;
  localparam int EN_CMP67_BIT  = 18;

  // ****************************************
  // Config register fields
  // ****************************************
  localparam int CFG_EXT_BIT   = 3;
  localparam logic [2:0] CFG_SLOT_RST = 3'h0;

  // ****************************************
  // Status bits
  // ****************************************
  localparam int ST_RAISED  = 0;
  localparam int ST_HELD    = 1;
  localparam int ST_LATE    = 2;
  localparam int NSTAT      = 3;

  // ****************************************
  // Timing, in nanoseconds
  // ****************************************
  localparam int CLK_NS          = 4;
  localparam int T_BASIC_NS      = 20000;
  localparam int T_BASIC_CMP_NS  = 70000;
  localparam int T_EXT_NS        = 250000;
  localparam int T_STEP_BASIC_NS = 50000;
  localparam int T_CMP_EXTRA_NS  = 50000;

  typedef enum {ST_IDLE, ST_LIST, ST_RAISE} cip_state_t;

  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } cip_apb_req_t;

endpackage : cip_pkg

// ==== sim/cip_checker_assertions.sv ====
// Port-level assertions of the counter interrupt prioritizer
`timescale 1ns/1ns
module cip_checker (
  // Clock and reset
  input wire logic        REF_CLK,
  input wire logic        RST_B,
  // APB
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Host side
  input wire logic        OUTPUT_DISABLE_COMMAND,
  input wire logic        INT_LINE,
  input wire logic [7:0]  SHARED_INTERRUPT_BYTE,
  input wire logic        LIST_START
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  logic [31:0] en_q;
  logic [2:0]  slot_q;
  logic        wr;
  assign wr = PSEL && PENABLE && PWRITE;
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      en_q   <= 32'h0;
      slot_q <= 3'h0;
    end else if (wr && PADDR == cip_pkg::OFF_ENABLE) begin
      en_q <= PWDATA;
    end else if (wr && PADDR == cip_pkg::OFF_CONFIG) begin
      slot_q <= PWDATA[2:0];
    end
  end
  sequence s_list_done;
    ##[0:200] (wr && PADDR == cip_pkg::OFF_CLDONE);
  endsequence
  chk_byte_slot: assert property (INT_LINE |-> SHARED_INTERRUPT_BYTE == 8'h01 << slot_q)
    else $error("shared byte bit differs from configured slot");
  chk_byte_idle: assert property (!INT_LINE |-> SHARED_INTERRUPT_BYTE == 8'h00)
    else $error("shared byte set without interrupt");
  chk_line_pulse: assert property ($rose(INT_LINE) |=> $fell(INT_LINE))
    else $error("interrupt line longer than one cycle");
  chk_hold_quiet: assert property (OUTPUT_DISABLE_COMMAND [*8] |-> !INT_LINE)
    else $error("interrupt raised while output disable held");
  chk_list_blocks: assert property
    (LIST_START |=> (!INT_LINE && !LIST_START) throughout s_list_done)
    else $error("raise or new list before list completion");
  chk_global_gate: assert property
    (!en_q[cip_pkg::EN_GLOBAL_BIT] |-> !INT_LINE && !LIST_START)
    else $error("interrupt activity without global enable");
  chk_setup_ready: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
    else $error("access phase not one cycle");
  chk_err_zero: assert property (PREADY && PSLVERR && !PWRITE |-> PRDATA == 32'h0)
    else $error("refused read returned data");
endmodule : cip_checker
bind cip_top cip_checker u_chk (.*);

// ==== sim/cip_host.sv ====
// Host processor model watching interrupt line and shared byte
`timescale 1ns/1ns
module cip_host (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Module side
  input  wire logic       int_line,
  input  wire logic [7:0] shared_interrupt_byte,
  output logic            output_disable_command,
  // Bench side
  input  wire logic       hold_req,
  output int              int_count,
  output logic [7:0]      live_periphery_byte
);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      int_count              <= 0;
      live_periphery_byte    <= 8'h00;
      output_disable_command <= 1'b0;
    end else begin
      output_disable_command <= hold_req;
      if (int_line) begin
        int_count           <= int_count + 1;
        live_periphery_byte <= shared_interrupt_byte;
      end
    end
  end
endmodule : cip_host

// ==== sim/cip_top_tb.sv ====
// Bench: registers, gating, priority, hold and reaction scenarios
`timescale 1ns/1ns
module cip_top_tb;
  logic        clk, rst_b, psel, penable, pwrite, busy, hold, od, il, pready, e;
  logic        pslverr, ls, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [14:0] ev;
  logic [7:0]  sib, live;
  logic [3:0]  lsrc;
  int          fail_count, tests_run, n;
  int          cyc = 0;
  cip_top #(.T_LIMIT_CYC(50)) DUT (.REF_CLK(clk), .RST_B(rst_b), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SRC_EVENT(ev), .CTRL_WORD_BUSY(busy),
    .OUTPUT_DISABLE_COMMAND(od), .INT_LINE(il), .SHARED_INTERRUPT_BYTE(sib),
    .LIST_START(ls), .LIST_SRC(lsrc), .IRQ(irq));
  cip_host host (.clk(clk), .rst_b(rst_b), .int_line(il), .shared_interrupt_byte(sib),
    .output_disable_command(od), .hold_req(hold), .int_count(n), .live_periphery_byte(live));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      give_verdict();
    end
  end
  task give_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  task fire(input logic [14:0] m);
    @(posedge clk);
    ev <= m;
    repeat (4) @(posedge clk);
    ev <= 15'h0;
  endtask : fire
  task wait_n(input int exp, input int lim);
    int k;
    k = 0;
    while (n < exp && k < lim) begin
      @(negedge clk);
      k++;
    end
    chk("interrupt count", exp, n);
  endtask : wait_n
  task serve(input logic [3:0] src);
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (ls !== 1'b1 && k < 3000);
    chk("list start", 32'h1, {31'h0, ls});
    chk("list source", {28'h0, src}, {28'h0, lsrc});
    bus(1'b1, cip_pkg::OFF_CLDONE, 32'h0);
  endtask : serve
  initial begin
    {fail_count, tests_run} = '0;
    {rst_b, psel, penable, pwrite, busy, hold, ev, paddr, pwdata} = '0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    bus(1'b0, cip_pkg::OFF_ENABLE, 32'h0);
    chk("enable reset", 32'h0, d);
    bus(1'b0, 12'h100, 32'h0);
    chk("unmapped refusal", 32'h1, {31'h0, e});
    fire(15'h0001);
    wait_n(0, 100);
    bus(1'b1, cip_pkg::OFF_CONFIG, 32'h5);
    bus(1'b1, cip_pkg::OFF_ENABLE, 32'h1);
    fire(15'h0001);
    wait_n(0, 100);
    bus(1'b1, cip_pkg::OFF_ENABLE, 32'h1_0001);
    fire(15'h0001);
    wait_n(1, 5000);
    chk("periphery byte", 32'h20, {24'h0, live});
    bus(1'b1, cip_pkg::OFF_ENABLE, 32'h1_4000);
    fire(15'h4000);
    wait_n(1, 200);
    bus(1'b1, cip_pkg::OFF_ENABLE, 32'h3_1401);
    fire(15'h4000);
    wait_n(2, 5000);
    fire(15'h1000);
    wait_n(2, 200);
    @(posedge clk);
    busy <= 1'b1;
    fire(15'h0001);
    wait_n(2, 200);
    @(posedge clk);
    busy <= 1'b0;
    wait_n(3, 5000);
    bus(1'b1, cip_pkg::OFF_CLLIST, 32'h0421);
    bus(1'b1, cip_pkg::OFF_ENABLE, 32'h3_0421);
    bus(1'b1, cip_pkg::OFF_CONFIG, 32'hd);
    bus(1'b1, cip_pkg::OFF_FILTER, 32'h20);
    fire(15'h0421);
    serve(4'h0);
    serve(4'h5);
    serve(4'ha);
    wait_n(5, 200);
    @(posedge clk);
    hold <= 1'b1;
    repeat (6) @(posedge clk);
    fire(15'h0401);
    wait_n(5, 200);
    @(posedge clk);
    hold <= 1'b0;
    serve(4'h0);
    serve(4'ha);
    wait_n(7, 200);
    bus(1'b1, cip_pkg::OFF_MASK, 32'h1);
    repeat (2) @(negedge clk);
    chk("irq raised", 32'h1, {31'h0, irq});
    bus(1'b0, cip_pkg::OFF_STATUS, 32'h0);
    chk("status raised", 32'h3, d & 32'h7);
    repeat (3) @(negedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    bus(1'b0, cip_pkg::OFF_STATUS, 32'h0);
    chk("status cleared", 32'h0, d);
    give_verdict();
  end
endmodule : cip_top_tb
